// [verilog/pims_pkg.sv]
package pims_pkg;

  // register offsets
  localparam logic [7:0] PIMS_OFS_MASK_PRIMARY = 8'h03;
  localparam logic [7:0] PIMS_OFS_MASK_SWITCH  = 8'h04;
  localparam logic [7:0] PIMS_OFS_STATE_REPORT = 8'h05;

  // reset values
  localparam logic [7:0] PIMS_RST_MASK_PRIMARY = 8'h00;
  localparam logic [7:0] PIMS_RST_MASK_SWITCH  = 8'h00;

  // writable bits (reserved bits 7-6 read zero)
  localparam logic [7:0] PIMS_WMASK_MASK       = 8'h3F;

  // field positions in the primary mask and its event flags
  localparam int PIMS_BIT_PROG_VOLT   = 5;
  localparam int PIMS_BIT_MAINS       = 4;
  localparam int PIMS_BIT_BUTTON      = 3;
  localparam int PIMS_BIT_THERMAL     = 2;
  localparam int PIMS_BIT_PROG_DONE   = 0;
  // field positions in the switch mask and its event flags
  localparam int PIMS_BIT_SW_FAULT    = 5;
  localparam int PIMS_BIT_SW_LIMIT    = 2;
  // field positions in the state report
  localparam int PIMS_BIT_NV_MOD      = 6;
  localparam int PIMS_BIT_MAINS_LVL   = 5;
  localparam int PIMS_BIT_BUTTON_LVL  = 4;
  localparam int PIMS_BIT_STATE_LO    = 2;

  // power state encoding shown in the state report
  typedef enum logic [1:0] {
    PIMS_PWR_TRANSITION = 2'h0,
    PIMS_PWR_AWAIT_EN   = 2'h1,
    PIMS_PWR_ACTIVE     = 2'h2,
    PIMS_PWR_SUSPEND    = 2'h3
  } pims_pwr_state_t;

  // pending event flags as delivered by the flag logic
  typedef struct packed {
    logic prog_voltage_event;
    logic mains_change_event;
    logic button_change_event;
    logic thermal_warn_event;
    logic prog_done_event;
    logic switch_fault_event;
    logic switch_limit_event;
  } pims_events_t;

  // register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pims_req_t;

endpackage : pims_pkg

// [verilog/pims_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of asynchronous levels
module pims_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // refuse an empty bundle at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("pims_sync: WIDTH must be at least 1");
  end

  // both stages in one state word
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } pims_sync_state_t;

  pims_sync_state_t st;
  pims_sync_state_t next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.meta = async_i;
    next_st.sync = st.meta;
  end

  // reset to the idle high level of active-low pins, so no false edge follows reset
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.sync;

endmodule : pims_sync

// [verilog/pims_irq_mask_status.sv]
`timescale 1ns/1ps
// Operation
// - primary bit 5 masks programming-voltage event
// - primary bit 4 masks mains-change event
// - primary bit 3 masks button-change event
// - primary bit 2 masks thermal-warning event
// - primary bit 0 masks programming-done event
// - switch bit 5 masks switch-fault event
// - switch bit 2 masks switch-limit event
// - masks never alter event flag recording
// - status bit 6 shows nonvolatile reprogrammed
// - status bit 5 is inverted mains pin
// - status bit 4 is inverted button pin
// - status bits 3-2 show power state
// - mains flag set on either pin edge
// - limit flag follows live current limiting
module pims_irq_mask_status
  import pims_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            reset_n_i,
  // register access from the serial slave
  input  wire pims_req_t       reg_req_i,
  output logic      [7:0]      reg_rdata_o,
  output logic                 reg_rvalid_o,
  // pending flags and live sources
  input  wire pims_events_t    flags_i,
  input  wire logic            switch_limiting_i,
  input  wire logic            mains_detect_input_i,
  input  wire logic            push_button_input_i,
  input  wire logic            nv_modified_i,
  input  wire pims_pwr_state_t pwr_state_i,
  // flag recording towards the flag registers
  output logic                 mains_change_set_o,
  output logic                 switch_limit_level_o,
  output pims_events_t         flags_seen_o,
  // open-drain interrupt pin
  output logic                 irq_out_low_o,
  output logic                 irq_out_low_oe_o
);

  // whole block state
  typedef struct packed {
    logic [7:0]   mask_primary;
    logic [7:0]   mask_switch;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         mains_prev;
    logic         mains_set;
    logic         limit_lvl;
    pims_events_t seen;
    logic         irq_level;
    logic         irq_oe;
  } pims_state_t;

  pims_state_t st;
  pims_state_t next_st;

  logic [1:0]  pins_sync;
  logic        mains_active;
  logic        button_active;
  logic        limit_sync;
  logic        nv_sync;
  logic        irq_pending;
  logic [7:0]  report;

  // top bit of every register word; bounds the package field positions
  localparam int REG_MSB = 7;

  // refuse field positions an 8-bit register cannot hold; a stray
  // constant would otherwise slice outside the word without a warning
  if (PIMS_BIT_PROG_VOLT > REG_MSB || PIMS_BIT_MAINS > REG_MSB || PIMS_BIT_BUTTON > REG_MSB ||
      PIMS_BIT_THERMAL > REG_MSB || PIMS_BIT_PROG_DONE > REG_MSB) begin : g_primary_check
    $error("primary mask field position out of range");
  end
  // switch mask fields
  if (PIMS_BIT_SW_FAULT > REG_MSB || PIMS_BIT_SW_LIMIT > REG_MSB) begin : g_switch_check
    $error("switch mask field position out of range");
  end
  // report fields; the power state field needs two bits
  if (PIMS_BIT_NV_MOD > REG_MSB || PIMS_BIT_MAINS_LVL > REG_MSB || PIMS_BIT_BUTTON_LVL > REG_MSB ||
      PIMS_BIT_STATE_LO > REG_MSB - 1) begin : g_report_check
    $error("report field position out of range");
  end
  // a write mask with no bit set would freeze both masks at reset
  if (PIMS_WMASK_MASK == 8'h00) begin : g_wmask_check
    $error("write mask leaves no writable bit");
  end

  // pins come from outside the clock domain
  pims_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    ({mains_detect_input_i, push_button_input_i}),
    .sync_o     (pins_sync)
  );

  // pins are active low
  assign mains_active  = ~pins_sync[1];
  assign button_active = ~pins_sync[0];
  assign limit_sync    = switch_limiting_i;
  assign nv_sync       = nv_modified_i;

  // gate each flag by its mask bit; flags themselves untouched
  always_comb begin
    irq_pending = 1'b0;
    if (flags_i.prog_voltage_event  && !st.mask_primary[PIMS_BIT_PROG_VOLT]) irq_pending = 1'b1;
    if (flags_i.mains_change_event  && !st.mask_primary[PIMS_BIT_MAINS])     irq_pending = 1'b1;
    if (flags_i.button_change_event && !st.mask_primary[PIMS_BIT_BUTTON])    irq_pending = 1'b1;
    if (flags_i.thermal_warn_event  && !st.mask_primary[PIMS_BIT_THERMAL])   irq_pending = 1'b1;
    if (flags_i.prog_done_event     && !st.mask_primary[PIMS_BIT_PROG_DONE]) irq_pending = 1'b1;
    if (flags_i.switch_fault_event  && !st.mask_switch[PIMS_BIT_SW_FAULT])   irq_pending = 1'b1;
    if (flags_i.switch_limit_event  && !st.mask_switch[PIMS_BIT_SW_LIMIT])   irq_pending = 1'b1;
  end

  // state report assembly; reserved bits read zero
  always_comb begin
    report = 8'h00;
    report[PIMS_BIT_NV_MOD]     = nv_sync;
    report[PIMS_BIT_MAINS_LVL]  = mains_active;
    report[PIMS_BIT_BUTTON_LVL] = button_active;
    report[PIMS_BIT_STATE_LO +: 2] = pwr_state_i;
  end

  // next state
  always_comb begin
    next_st        = st;
    next_st.rvalid = reg_req_i.rd;
    // register writes; reserved bits stay zero
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        PIMS_OFS_MASK_PRIMARY: next_st.mask_primary = reg_req_i.wdata & PIMS_WMASK_MASK;
        PIMS_OFS_MASK_SWITCH:  next_st.mask_switch  = reg_req_i.wdata & PIMS_WMASK_MASK;
        default: ;
      endcase
    end
    // register reads; unmapped offsets answer zero
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        PIMS_OFS_MASK_PRIMARY: next_st.rdata = st.mask_primary;
        PIMS_OFS_MASK_SWITCH:  next_st.rdata = st.mask_switch;
        PIMS_OFS_STATE_REPORT: next_st.rdata = report;
        default:               next_st.rdata = 8'h00;
      endcase
    end
    // either pin edge is one set pulse
    next_st.mains_prev = mains_active;
    next_st.mains_set  = mains_active ^ st.mains_prev;
    // limit flag is a live level, not sticky
    next_st.limit_lvl  = limit_sync;
    // flags pass through unchanged regardless of masks
    next_st.seen       = flags_i;
    // drive low while any unmasked flag pending
    next_st.irq_level  = 1'b0;
    next_st.irq_oe     = irq_pending;
  end

  // masks leave reset cleared, so every source can reach the pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st              <= '0;
      st.mask_primary <= PIMS_RST_MASK_PRIMARY;
      st.mask_switch  <= PIMS_RST_MASK_SWITCH;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o          = st.rdata;
  assign reg_rvalid_o         = st.rvalid;
  assign mains_change_set_o   = st.mains_set;
  assign switch_limit_level_o = st.limit_lvl;
  assign flags_seen_o         = st.seen;
  assign irq_out_low_o        = st.irq_level;
  assign irq_out_low_oe_o     = st.irq_oe;

  // checks
  chk_prog_volt_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.prog_voltage_event && !st.mask_primary[PIMS_BIT_PROG_VOLT]) |=> irq_out_low_oe_o)
    else $error("unmasked programming-voltage flag did not pull interrupt");
  chk_mains_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.mains_change_event && !st.mask_primary[PIMS_BIT_MAINS]) |=> irq_out_low_oe_o)
    else $error("unmasked mains flag did not pull interrupt");
  chk_button_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.button_change_event && !st.mask_primary[PIMS_BIT_BUTTON]) |=> irq_out_low_oe_o)
    else $error("unmasked button flag did not pull interrupt");
  chk_thermal_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.thermal_warn_event && !st.mask_primary[PIMS_BIT_THERMAL]) |=> irq_out_low_oe_o)
    else $error("unmasked thermal flag did not pull interrupt");
  chk_prog_done_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.prog_done_event && !st.mask_primary[PIMS_BIT_PROG_DONE]) |=> irq_out_low_oe_o)
    else $error("unmasked programming-done flag did not pull interrupt");
  chk_fault_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.switch_fault_event && !st.mask_switch[PIMS_BIT_SW_FAULT]) |=> irq_out_low_oe_o)
    else $error("unmasked switch fault did not pull interrupt");
  chk_limit_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (flags_i.switch_limit_event && !st.mask_switch[PIMS_BIT_SW_LIMIT]) |=> irq_out_low_oe_o)
    else $error("unmasked switch limit did not pull interrupt");
  chk_flags_pass: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 flags_seen_o == $past(flags_i))
    else $error("flag recording altered");
  chk_nv_report: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_req_i.rd && reg_req_i.addr == PIMS_OFS_STATE_REPORT)
      |=> reg_rvalid_o && reg_rdata_o[PIMS_BIT_NV_MOD] == $past(nv_modified_i))
    else $error("nonvolatile status bit wrong");

  sequence s_mains_low_held;
    !mains_detect_input_i [*3];
  endsequence
  chk_mains_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_mains_low_held |-> mains_active)
    else $error("mains level not reported active");
  chk_button_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (push_button_input_i [*3]) |-> !button_active)
    else $error("button level not reported inactive");
  chk_state_field: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_req_i.rd && reg_req_i.addr == PIMS_OFS_STATE_REPORT)
      |=> reg_rdata_o[PIMS_BIT_STATE_LO +: 2] == $past(pwr_state_i))
    else $error("power state field wrong");
  // a pin edge shows as a changed synchronised level first
  sequence s_mains_edge_seen;
    $changed(mains_active);
  endsequence
  chk_mains_edge: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_mains_edge_seen |=> mains_change_set_o)
    else $error("mains edge did not set flag");
  chk_limit_live: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 switch_limit_level_o == $past(switch_limiting_i))
    else $error("limit level not tracking");
  chk_irq_release: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !irq_pending |=> !irq_out_low_oe_o && !irq_out_low_o)
    else $error("interrupt held with nothing pending");

  // register requests as one-edge strobes, and held pin levels
  sequence s_write_primary;
    reg_req_i.wr && reg_req_i.addr == PIMS_OFS_MASK_PRIMARY;
  endsequence
  sequence s_write_switch;
    reg_req_i.wr && reg_req_i.addr == PIMS_OFS_MASK_SWITCH;
  endsequence
  sequence s_read_any;
    reg_req_i.rd;
  endsequence
  sequence s_button_low_held;
    !push_button_input_i [*3];
  endsequence
  sequence s_mains_high_held;
    mains_detect_input_i [*3];
  endsequence

  // a mask write lands on the next edge, reserved bits dropped
  chk_primary_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_write_primary |=> st.mask_primary == ($past(reg_req_i.wdata) & PIMS_WMASK_MASK))
    else $error("primary mask write did not land");
  chk_switch_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_write_switch |=> st.mask_switch == ($past(reg_req_i.wdata) & PIMS_WMASK_MASK))
    else $error("switch mask write did not land");
  // reserved mask bits never hold a one
  chk_mask_reserved: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ((st.mask_primary | st.mask_switch) & ~PIMS_WMASK_MASK) == 8'h00)
    else $error("reserved mask bit set");
  // a read answer is a single pulse one edge after the request
  chk_read_pulse: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_read_any |=> reg_rvalid_o)
    else $error("read not answered");
  chk_read_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !reg_req_i.rd |=> !reg_rvalid_o)
    else $error("read answer without request");
  // unmapped offsets answer zero
  chk_unmapped_read: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_req_i.rd && reg_req_i.addr != PIMS_OFS_MASK_PRIMARY && reg_req_i.addr != PIMS_OFS_MASK_SWITCH
      && reg_req_i.addr != PIMS_OFS_STATE_REPORT) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // the report is read-only; a write there leaves both masks alone
  chk_report_readonly: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_req_i.wr && reg_req_i.addr == PIMS_OFS_STATE_REPORT)
      |=> $stable(st.mask_primary) && $stable(st.mask_switch))
    else $error("report write changed a mask");
  // open-drain data is always low; the enable alone moves the pin
  chk_irq_data_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !irq_out_low_o)
    else $error("interrupt pin data driven high");
  // every source masked keeps the pin released
  chk_all_masked: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (st.mask_primary == PIMS_WMASK_MASK && st.mask_switch == PIMS_WMASK_MASK) |=> !irq_out_low_oe_o)
    else $error("interrupt pulled with every source masked");
  // no pin edge, no change pulse
  chk_mains_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $stable(mains_active) |=> !mains_change_set_o)
    else $error("mains pulse without pin edge");
  // held pin levels show up in the level flags: button held low as active, mains held high as inactive
  chk_button_active: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_button_low_held |-> button_active)
    else $error("button level not reported active");
  chk_mains_inactive: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_mains_high_held |-> !mains_active)
    else $error("mains level not reported inactive");
  // a read of the report carries the synchronised pin bits
  chk_pins_report: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_req_i.rd && reg_req_i.addr == PIMS_OFS_STATE_REPORT)
      |=> reg_rdata_o[PIMS_BIT_MAINS_LVL] == $past(mains_active)
        && reg_rdata_o[PIMS_BIT_BUTTON_LVL] == $past(button_active))
    else $error("pin levels wrong in report");

endmodule : pims_irq_mask_status

// [bench/pims_host_model.sv]
`timescale 1ns/1ps
// host side of the open-drain interrupt pin with its pull-up
module pims_host_model (
  // pin from the device
  input  wire logic irq_out_low_i,
  input  wire logic irq_out_low_oe_i,
  // level the host sees
  output logic      irq_line_o
);
  // a released pin floats up to the pull-up level, never the last value
  assign irq_line_o = irq_out_low_oe_i ? irq_out_low_i : 1'b1;
endmodule : pims_host_model

// [bench/test_pims_irq_mask_status.sv]
`timescale 1ns/1ps
module test_pims_irq_mask_status
  import pims_pkg::*;
;
  logic            core_clk_i, reset_n_i, rvalid, limiting, mains_pin, button_pin, nv_mod;
  logic            mains_set, limit_lvl, irq_lo, irq_oe, irq_line;
  logic [7:0]      rdata;
  pims_req_t       req;
  pims_events_t    flags, seen;
  pims_pwr_state_t pwr;
  int              err_count, n_tests;
  int              mbit [7] = '{2, 5, 0, 2, 3, 4, 5};
  logic [7:0]      maddr, exp_v;

  pims_irq_mask_status dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .flags_i(flags), .switch_limiting_i(limiting),
    .mains_detect_input_i(mains_pin), .push_button_input_i(button_pin), .nv_modified_i(nv_mod),
    .pwr_state_i(pwr), .mains_change_set_o(mains_set), .switch_limit_level_o(limit_lvl),
    .flags_seen_o(seen), .irq_out_low_o(irq_lo), .irq_out_low_oe_o(irq_oe));
  pims_host_model host (.irq_out_low_i(irq_lo), .irq_out_low_oe_i(irq_oe), .irq_line_o(irq_line));

  // 100 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // one-cycle write strobe, driven between edges
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk_i);
    req.wr = 1'b1; req.addr = addr; req.wdata = data;
    @(negedge core_clk_i);
    req.wr = 1'b0;
  endtask : reg_write

  // answer stands for one cycle right after the taking edge
  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp_v, input logic [7:0] msk);
    @(negedge core_clk_i);
    req.rd = 1'b1; req.addr = addr;
    @(negedge core_clk_i);
    req.rd = 1'b0;
    check("read valid", {7'h00, rvalid}, 8'h01);
    check("read data", rdata & msk, exp_v);
  endtask : reg_read

  // an edge on the mains pin must be reported within a few cycles
  task automatic wait_mains_pulse();
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk_i);
      if (mains_set === 1'b1) begin
        check("mains pulse delay", k[7:0], 8'h02);
        return;
      end
    end
    err_count++;
    $display("mismatch mains change pulse expected 1 seen none");
    report_and_stop();
  endtask : wait_mains_pulse

  initial begin
    reset_n_i = 1'b0; req = '0; flags = '0; limiting = 1'b0; mains_pin = 1'b1;
    button_pin = 1'b1; nv_mod = 1'b0; pwr = PIMS_PWR_TRANSITION; err_count = 0; n_tests = 0;
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    // reset values, reserved bits, read-only and unmapped places
    reg_read(PIMS_OFS_MASK_PRIMARY, PIMS_RST_MASK_PRIMARY, 8'hFF);
    reg_read(PIMS_OFS_MASK_SWITCH, PIMS_RST_MASK_SWITCH, 8'hFF);
    reg_write(PIMS_OFS_MASK_PRIMARY, 8'hFF);
    reg_read(PIMS_OFS_MASK_PRIMARY, 8'h3F, 8'hFF);
    reg_write(PIMS_OFS_MASK_SWITCH, 8'hFF);
    reg_read(PIMS_OFS_MASK_SWITCH, 8'h3F, 8'hFF);
    reg_write(PIMS_OFS_STATE_REPORT, 8'h00);
    reg_write(8'h40, 8'h00);
    reg_read(PIMS_OFS_MASK_PRIMARY, 8'h3F, 8'hFF);
    reg_read(PIMS_OFS_MASK_SWITCH, 8'h3F, 8'hFF);
    reg_read(8'h40, 8'h00, 8'hFF);
    $display("test registers done");
    // each event against its own mask bit, all other bits set or clear
    for (int i = 0; i < 7; i++) begin
      maddr = (i >= 2) ? PIMS_OFS_MASK_PRIMARY : PIMS_OFS_MASK_SWITCH;
      reg_write(PIMS_OFS_MASK_PRIMARY, 8'h00);
      reg_write(PIMS_OFS_MASK_SWITCH, 8'h00);
      reg_write(maddr, 8'h3F ^ (8'h01 << mbit[i]));
      flags = pims_events_t'(7'h01 << i);
      repeat (3) @(negedge core_clk_i);
      check("irq line unmasked", {7'h00, irq_line}, 8'h00);
      reg_write(maddr, 8'h01 << mbit[i]);
      repeat (3) @(negedge core_clk_i);
      check("irq line masked", {7'h00, irq_line}, 8'h01);
      check("flags seen", {1'b0, seen}, {1'b0, flags});
      flags = '0;
    end
    $display("test masking done");
    // live pins, nonvolatile state and power state in the report
    for (int s = 0; s < 4; s++) begin
      mains_pin = s[0]; button_pin = s[1]; nv_mod = s[0] ^ s[1]; pwr = pims_pwr_state_t'(s);
      repeat (4) @(negedge core_clk_i);
      exp_v = {1'b0, nv_mod, ~mains_pin, ~button_pin, s[1:0], 2'b00};
      reg_read(PIMS_OFS_STATE_REPORT, exp_v, 8'hFC);
    end
    $display("test status done");
    // mains edges in both directions, then the limit level
    repeat (2) begin
      mains_pin = ~mains_pin;
      wait_mains_pulse();
      @(negedge core_clk_i);
      check("mains pulse single", {7'h00, mains_set}, 8'h00);
    end
    limiting = 1'b1;
    repeat (3) @(negedge core_clk_i);
    check("limit level on", {7'h00, limit_lvl}, 8'h01);
    limiting = 1'b0;
    repeat (3) @(negedge core_clk_i);
    check("limit level off", {7'h00, limit_lvl}, 8'h00);
    $display("test events done");
    report_and_stop();
  end
endmodule : test_pims_irq_mask_status
